// ### logic/smc_pkg.sv
// Package of constants for the system mode and configuration controller
package smc_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_WD_MISS = 8'h14;
  // Control register fields
  localparam int CTRL_SECOND_MISS = 0;
  localparam int CTRL_CFG_OVR_EN = 1;
  localparam int CTRL_CFG_OVR_LSB = 4;
  // Interrupt status bits
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_WD_FAIL = 1;
  localparam int IRQ_INIT_TO = 2;
  localparam int IRQ_WIDTH = 3;
  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [IRQ_WIDTH-1:0] MASK_RESET = 3'h0;
  // Mode select codes written by the host
  localparam logic [2:0] MS_NORMAL = 3'h1;
  localparam logic [2:0] MS_SLEEP = 3'h2;
  localparam logic [2:0] MS_STOP = 3'h3;
  localparam logic [2:0] MS_SW_FLASH = 3'h4;
  localparam logic [2:0] MS_RESTART = 3'h5;
  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int INIT_TIMEOUT_MS = 256;
  localparam int INIT_TIMEOUT_CYC = INIT_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int RESET_DELAY_US = 10;
  localparam int RESET_DELAY_CYC = RESET_DELAY_US * (CLK_HZ / 1_000_000);
  // Device operating modes
  typedef enum logic [3:0] {
    MODE_POR = 4'h0,
    MODE_INIT = 4'h1,
    MODE_NORMAL = 4'h2,
    MODE_RESTART = 4'h3,
    MODE_SW_FLASH = 4'h4,
    MODE_SLEEP = 4'h5,
    MODE_STOP = 4'h6,
    MODE_FAIL_SAFE = 4'h7,
    MODE_SW_DEV = 4'h8,
    MODE_FACTORY_FLASH = 4'h9
  } smc_mode_type;
endpackage : smc_pkg

// ### logic/smc_ctrl.sv
// Mode and configuration controller with APB register access
//
// Contract
// - Drive interrupt pin low on stop wake-up and on detected failures.
// - Sample interrupt pin at start-up: pull-up gives config 1/3, else 2/4.
// - Mode chosen from development pin plus three-bit host mode select field.
// - Five configurations from two pins and one serial configuration bit.
// - Development pin low selects config 0 unless the control override selects config 1 to 4.
// - Development pin high: config from pull-up level and second-miss bit.
// - Configs 1 and 2 react on the first missed watchdog trigger.
// - Configs 3 and 4 react only on the second missed trigger.
// - Configs 1 and 3: regulator kept, fail-safe asserted, go restart.
// - Configs 2 and 4: regulator off, fail-safe asserted, go fail-safe.
// - In development mode configs 1 to 4 remain selectable and usable.
// - Fail-safe output is open-drain, active low.
// - Hold reset output for reset delay after regulator good, then init.
// - No normal or flash command within 256 ms of reset release: restart.
//
// Register map, one aligned 32-bit word each
//   0x00 control: bit 0 second-miss select, bit 1 override enable,
//        bits 6:4 override configuration, honoured in development mode only
//   0x04 mode select field, three bits, host command
//   0x08 status, read only:
//        bits 3:0 operating mode code
//        bits 5:4 read as zero
//        bit 6 fail-safe output active
//        bit 7 main regulator enabled
//        bit 8 development pin active
//        bit 9 sampled interrupt-pin pull-up
//        bits 12:10 active configuration 0..4
//   0x0C interrupt status, write one to clear
//        bit 0 wake-up from stop, bit 1 watchdog failure, bit 2 init timeout
//   0x10 interrupt mask, a one masks the bit of the same position
//   0x14 watchdog miss count, read only
//   Other offsets read zero and ignore writes; no error response
//
// Bus timing
//   Read data is captured at the setup edge, so the access phase has no
//   wait state and pready is tied high. The trade-off is that a register
//   changing in the setup cycle is reported with its old value.
//
// Mode sequencing
//   Power-on: reset output held while the regulator is below threshold and
//   then for the reset delay; the counter restarts whenever the regulator
//   drops during this phase, so a glitchy supply never shortens the pulse.
//   Init: only normal or software flash commands are accepted; anything else
//   is ignored and the init timer keeps running.
//   Init timeout: restart mode and fail-safe output, with an interrupt.
//   Restart: reset output held for the reset delay, then normal or
//   development mode depending on the development pin.
//   Fail-safe: terminal until reset; the regulator stays off.
//
// Host commands
//   A write to the mode select offset raises a one-cycle pending strobe.
//   The strobe, not the stored field, triggers the transition, so an old
//   command is never replayed when the mode later changes by itself.
//   A watchdog failure in the same cycle as a command wins over the command.
//
// Watchdog reaction
//   Watched modes: normal, stop and development.
//   Configuration 0 inhibits the reaction entirely so that software can be
//   debugged with a halted core.
//   Configurations 3 and 4 count misses; the count clears on reaction and
//   whenever the watchdog is not watched, so misses carry over only between watched modes.
//
// Interrupts
//   Status bits are sticky; a new event in the same cycle as a clear wins,
//   so no event is lost to a racing acknowledge.
//   The interrupt pin is only driven after the pull-up sample is taken, so
//   start-up sampling never sees the device's own drive.
//
// Pins
//   All three pins are open drain: the data output is constant low and the
//   enable carries the information. The board supplies the pull-ups.
//
// Limitations
//   The configuration sample is taken at the first enabled edge after
//   reset; the interrupt pin must settle before then.
//   Clock enable low freezes every timer, including the init timeout.
//
`timescale 1ns/1ps
module smc_ctrl
  import smc_pkg::*;
#(
  parameter int INIT_TIMEOUT = INIT_TIMEOUT_CYC,
  parameter int RESET_DELAY = RESET_DELAY_CYC
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device pins and events
  input wire logic dev_entry_n,
  input wire logic int_pin_in,
  input wire logic main_reg_good,
  input wire logic wd_miss,
  input wire logic stop_wake,
  // Open-drain outputs, enable high while pulling low; then regulator enable and irq
  output logic int_pin_out,
  output logic int_pin_oe,
  output logic fail_safe_output_out,
  output logic fail_safe_output_oe,
  output logic reset_output_out,
  output logic reset_output_oe,
  output logic main_regulator_en,
  output logic irq
);

  // Register state
  logic [31:0] ctrl_ff;
  logic [2:0] mode_select_field_ff;
  logic [IRQ_WIDTH-1:0] irq_stat_ff;
  logic [IRQ_WIDTH-1:0] irq_mask_ff;
  smc_mode_type mode_ff;
  smc_mode_type nxt_mode;
  logic pullup_ff;
  logic sampled_ff;
  logic dev_ff;
  logic [1:0] miss_cnt_ff;
  logic [31:0] cnt_ff;
  logic fail_safe_ff;
  logic reg_on_ff;
  logic int_drive_ff;
  logic [31:0] prdata_ff;
  logic irq_ff;
  logic pending_cmd_ff;

  // Bus decode
  wire wr_en = clk_en & psel & penable & pwrite;
  wire rd_setup = clk_en & psel & ~penable & ~pwrite;
  wire sel_ctrl = (paddr == ADDR_CTRL);
  wire sel_mode = (paddr == ADDR_MODE);
  wire sel_stat = (paddr == ADDR_STAT);
  wire sel_istat = (paddr == ADDR_IRQ_STAT);
  wire sel_imask = (paddr == ADDR_IRQ_MASK);
  wire sel_miss = (paddr == ADDR_WD_MISS);
  wire mapped = sel_ctrl | sel_mode | sel_stat | sel_istat | sel_imask | sel_miss;

  // Configuration number 0..4 from pin, sampled pull-up and select bit
  function automatic logic [2:0] cfg_of(input logic dev, input logic pu, input logic second);
    logic [2:0] c;
    c = 3'h0;
    if (dev) begin
      c = 3'h0;
    end else begin
      c = {1'b0, second, 1'b0} + (pu ? 3'h1 : 3'h2);
    end
    return c;
  endfunction : cfg_of

  wire dev_mode = ~dev_entry_n;
  wire ovr_en = ctrl_ff[CTRL_CFG_OVR_EN];
  wire [2:0] ovr_cfg = ctrl_ff[CTRL_CFG_OVR_LSB +: 3];
  wire [2:0] pin_cfg = cfg_of(dev_mode, pullup_ff, ctrl_ff[CTRL_SECOND_MISS]);
  // Override only honoured in development mode and only for codes 1..4
  wire ovr_ok = dev_mode & ovr_en & (ovr_cfg >= 3'h1) & (ovr_cfg <= 3'h4);
  wire [2:0] active_cfg = ovr_ok ? ovr_cfg : pin_cfg;
  wire cfg_second = (active_cfg == 3'h3) | (active_cfg == 3'h4);
  wire cfg_keep_reg = (active_cfg == 3'h1) | (active_cfg == 3'h3);
  // Config 0 inhibits the watchdog reaction entirely
  wire wd_active = (active_cfg != 3'h0) &
                   ((mode_ff == MODE_NORMAL) | (mode_ff == MODE_STOP) | (mode_ff == MODE_SW_DEV));
  wire wd_fail = wd_active & wd_miss & (~cfg_second | (miss_cnt_ff != 2'h0));
  wire init_to = (mode_ff == MODE_INIT) & (cnt_ff >= INIT_TIMEOUT - 1);
  wire [IRQ_WIDTH-1:0] irq_evt = {init_to, wd_fail, stop_wake & (mode_ff == MODE_STOP)};
  wire w1c = wr_en & sel_istat;
  wire [IRQ_WIDTH-1:0] nxt_istat =
    irq_evt | (irq_stat_ff & ~(w1c ? pwdata[IRQ_WIDTH-1:0] : {IRQ_WIDTH{1'b0}}));
  wire mode_wr = wr_en & sel_mode;
  wire [31:0] rd_mux =
    sel_ctrl ? ctrl_ff :
    sel_mode ? {29'h0, mode_select_field_ff} :
    sel_stat ? {19'h0, active_cfg, pullup_ff, dev_mode, reg_on_ff, fail_safe_ff, 2'b00, mode_ff} :
    sel_istat ? {29'h0, irq_stat_ff} :
    sel_imask ? {29'h0, irq_mask_ff} :
    sel_miss ? {30'h0, miss_cnt_ff} : 32'h0;

  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      MODE_POR: if (cnt_ff >= RESET_DELAY - 1) nxt_mode = MODE_INIT;
      MODE_INIT: begin
        if (init_to) begin
          nxt_mode = MODE_RESTART;
        end else if (pending_cmd_ff && mode_select_field_ff == MS_NORMAL) begin
          nxt_mode = dev_mode ? MODE_SW_DEV : MODE_NORMAL;
        end else if (pending_cmd_ff && mode_select_field_ff == MS_SW_FLASH) begin
          nxt_mode = MODE_SW_FLASH;
        end
      end
      MODE_RESTART: if (cnt_ff >= RESET_DELAY - 1) nxt_mode = dev_mode ? MODE_SW_DEV : MODE_NORMAL;
      MODE_NORMAL, MODE_SW_DEV, MODE_STOP, MODE_SLEEP, MODE_SW_FLASH: begin
        if (pending_cmd_ff) begin
          unique case (mode_select_field_ff)
            MS_SLEEP: nxt_mode = MODE_SLEEP;
            MS_STOP: nxt_mode = MODE_STOP;
            MS_SW_FLASH: nxt_mode = MODE_SW_FLASH;
            MS_RESTART: nxt_mode = MODE_RESTART;
            MS_NORMAL: nxt_mode = dev_mode ? MODE_SW_DEV : MODE_NORMAL;
            default: nxt_mode = mode_ff;
          endcase
        end
        if (wd_fail) begin
          nxt_mode = cfg_keep_reg ? MODE_RESTART : MODE_FAIL_SAFE;
        end
      end
      MODE_FAIL_SAFE, MODE_FACTORY_FLASH: nxt_mode = mode_ff;
      default: nxt_mode = MODE_POR;
    endcase
  end

  // Mode state and timers; POR waits for regulator before counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= MODE_POR;
      cnt_ff <= 32'h0;
    end else if (clk_en) begin
      mode_ff <= nxt_mode;
      if (nxt_mode != mode_ff || (mode_ff == MODE_POR && !main_reg_good)) begin
        cnt_ff <= 32'h0;
      end else begin
        cnt_ff <= cnt_ff + 32'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_ff <= 1'b0;
      sampled_ff <= 1'b0;
      dev_ff <= 1'b0;
    end else if (clk_en && !sampled_ff) begin
      pullup_ff <= int_pin_in;
      dev_ff <= dev_mode;
      sampled_ff <= 1'b1;
    end
  end

  // Miss counter; cleared on reaction or when leaving watched modes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miss_cnt_ff <= 2'h0;
    end else if (clk_en) begin
      if (wd_fail || !wd_active) begin
        miss_cnt_ff <= 2'h0;
      end else if (wd_miss) begin
        miss_cnt_ff <= miss_cnt_ff + 2'h1;
      end
    end
  end

  // Fail-safe and regulator state; fail-safe stays until power-on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_safe_ff <= 1'b0;
      reg_on_ff <= 1'b0;
    end else if (clk_en) begin
      if (wd_fail || init_to) begin
        fail_safe_ff <= 1'b1;
      end
      if (wd_fail && !cfg_keep_reg) begin
        reg_on_ff <= 1'b0;
      end else if (mode_ff == MODE_SLEEP || nxt_mode == MODE_FAIL_SAFE) begin
        reg_on_ff <= 1'b0;
      end else if (mode_ff != MODE_FAIL_SAFE) begin
        reg_on_ff <= 1'b1;
      end
    end
  end

  // Registers written by software; set wins over write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RESET;
      mode_select_field_ff <= 3'h0;
      pending_cmd_ff <= 1'b0;
      irq_stat_ff <= '0;
      irq_mask_ff <= MASK_RESET;
    end else if (clk_en) begin
      irq_stat_ff <= nxt_istat;
      if (wr_en && sel_ctrl) ctrl_ff <= pwdata;
      if (wr_en && sel_imask) irq_mask_ff <= pwdata[IRQ_WIDTH-1:0];
      if (mode_wr) mode_select_field_ff <= pwdata[2:0];
      pending_cmd_ff <= mode_wr;
    end
  end

  // Output flops; pins are open-drain so out is always low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_drive_ff <= 1'b0;
      irq_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else if (clk_en) begin
      int_drive_ff <= sampled_ff & (|(nxt_istat & ~irq_mask_ff));
      irq_ff <= |(nxt_istat & ~irq_mask_ff);
      if (rd_setup) prdata_ff <= rd_mux;
    end
  end

  // Zero-wait APB: data captured in setup, ready always high in access
  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign int_pin_out = 1'b0;
  assign int_pin_oe = int_drive_ff;
  assign fail_safe_output_out = 1'b0;
  assign fail_safe_output_oe = fail_safe_ff;
  assign reset_output_out = 1'b0;
  assign reset_output_oe = (mode_ff == MODE_POR) | (mode_ff == MODE_RESTART);
  assign main_regulator_en = reg_on_ff;
  assign irq = irq_ff;

endmodule : smc_ctrl

// ### sim/smc_pins.sv
// Board model: pull-ups and straps around the open-drain pins
`timescale 1ns/1ps
module smc_pins (
  // Strap
  input wire logic ext_pullup,
  // Device drivers
  input wire logic int_pin_out,
  input wire logic int_pin_oe,
  input wire logic fail_safe_output_out,
  input wire logic fail_safe_output_oe,
  // Resolved lines
  output logic int_line,
  output logic fs_line
);
  // strap read
  // Undriven interrupt pin shows the strap, so start-up sampling sees it
  assign int_line = int_pin_oe ? int_pin_out : ext_pullup;
  assign fs_line = fail_safe_output_oe ? fail_safe_output_out : 1'b1;
endmodule : smc_pins

// ### sim/smc_ctrl_properties.sv
// Port-level assertions for the mode and configuration controller
`timescale 1ns/1ps
module smc_ctrl_props #(
  parameter int INIT_TIMEOUT = 50,
  parameter int RESET_DELAY = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus answer
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic int_pin_out,
  input wire logic int_pin_oe,
  input wire logic fail_safe_output_out,
  input wire logic fail_safe_output_oe,
  input wire logic reset_output_out,
  input wire logic reset_output_oe,
  input wire logic main_regulator_en,
  input wire logic irq
);
  logic [7:0] rc_ff;
  logic [7:0] hc_ff;
  // Cycles since release, and length of the present reset pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_ff <= 8'h00;
      hc_ff <= 8'h00;
    end else begin
      rc_ff <= (rc_ff == 8'hFF) ? rc_ff : rc_ff + 8'h01;
      hc_ff <= reset_output_oe ? hc_ff + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_od_low;
    !int_pin_out && !fail_safe_output_out && !reset_output_out;
  endproperty
  a_od_low: assert property (p_od_low)
    else $error("open-drain output driven high");
  property p_int_flag;
    int_pin_oe == irq;
  endproperty
  a_int_flag: assert property (p_int_flag)
    else $error("interrupt pin differs from irq");
  property p_fs_sticky;
    fail_safe_output_oe |=> fail_safe_output_oe;
  endproperty
  a_fs_sticky: assert property (p_fs_sticky)
    else $error("fail-safe output released");
  property p_reg_off;
    fail_safe_output_oe && !main_regulator_en |=> !main_regulator_en [*3];
  endproperty
  a_reg_off: assert property (p_reg_off)
    else $error("regulator back on in fail-safe");
  property p_fs_react;
    $rose(fail_safe_output_oe) |-> ##[0:3] (reset_output_oe || !main_regulator_en);
  endproperty
  a_fs_react: assert property (p_fs_react)
    else $error("fail-safe without restart or regulator off");
  property p_rst_early;
    rc_ff >= 8'h01 && rc_ff < RESET_DELAY |-> reset_output_oe;
  endproperty
  a_rst_early: assert property (p_rst_early)
    else $error("reset output released early");
  property p_rst_hold;
    $fell(reset_output_oe) && !fail_safe_output_oe |-> hc_ff >= RESET_DELAY;
  endproperty
  a_rst_hold: assert property (p_rst_hold)
    else $error("reset pulse too short");
  property p_apb;
    pready && !pslverr;
  endproperty
  a_apb: assert property (p_apb)
    else $error("bus access not completed");
  // Main scenarios reached
  c_fs: cover property ($rose(fail_safe_output_oe));
  c_irq: cover property ($rose(irq));
  c_reg: cover property ($fell(main_regulator_en));
endmodule : smc_ctrl_props
bind smc_ctrl smc_ctrl_props #(.INIT_TIMEOUT(INIT_TIMEOUT), .RESET_DELAY(RESET_DELAY))
  u_smc_ctrl_props (.pclk(pclk), .presetn(presetn), .pready(pready), .pslverr(pslverr),
  .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe), .irq(irq),
  .fail_safe_output_out(fail_safe_output_out), .fail_safe_output_oe(fail_safe_output_oe),
  .reset_output_out(reset_output_out), .reset_output_oe(reset_output_oe),
  .main_regulator_en(main_regulator_en));

// ### sim/tb_smc_ctrl.sv
// Register-level testbench for the mode and configuration controller
`timescale 1ns/1ps
module tb_smc_ctrl;
  import smc_pkg::*;
  localparam int RD = 4;
  localparam int TO = 50;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic wd_miss = 1'b0, stop_wake = 1'b0, dev_entry_n = 1'b1, ext_pu = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, int_pin_oe, int_pin_out, fs_out, fs_oe, reg_en, irq, int_line, fs_line;
  int n_errors = 0, tests_run = 0;
  smc_ctrl #(.INIT_TIMEOUT(TO), .RESET_DELAY(RD)) u_smc_ctrl (.pclk(pclk), .presetn(presetn),
    .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dev_entry_n(dev_entry_n), .int_pin_in(int_line), .main_reg_good(1'b1),
    .wd_miss(wd_miss), .stop_wake(stop_wake), .int_pin_out(int_pin_out),
    .int_pin_oe(int_pin_oe), .fail_safe_output_out(fs_out), .fail_safe_output_oe(fs_oe),
    .reset_output_out(), .reset_output_oe(), .main_regulator_en(reg_en), .irq(irq));
  smc_pins u_smc_pins (.ext_pullup(ext_pu), .int_pin_out(int_pin_out),
    .int_pin_oe(int_pin_oe), .fail_safe_output_out(fs_out), .fail_safe_output_oe(fs_oe),
    .int_line(int_line), .fs_line(fs_line));
  initial forever #50 pclk = ~pclk;
  task automatic end_of_test;
    $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Setup then access phase; data taken at the edge where pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask : rd
  task automatic pulse(input logic miss);
    @(posedge pclk);
    if (miss) wd_miss <= 1'b1;
    else stop_wake <= 1'b1;
    @(posedge pclk);
    {wd_miss, stop_wake} <= 2'b00;
  endtask : pulse
  // Bounded wait for the fail-safe reaction, then the line must be low
  task automatic wait_fs;
    int n;
    n = 0;
    while (fs_oe !== 1'b1 && n < 200) begin
      @(negedge pclk);
      n++;
    end
    chk({31'h0, fs_line}, 32'h0);
  endtask : wait_fs
  task automatic rst(input logic pu, input logic dev);
    {presetn, ext_pu, dev_entry_n} <= {1'b0, pu, dev};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (RD + 6) @(posedge pclk);
  endtask : rst
  initial begin
    #(100 * 20000);
    n_errors++;
    end_of_test;
  end
  initial begin
    rst(1'b1, 1'b1);
    rd(ADDR_STAT, 32'hFFFF_FFFF, 32'h0000_0681);
    rd(ADDR_IRQ_MASK, 32'hFFFF_FFFF, 32'h0);
    rd(8'h18, 32'hFFFF_FFFF, 32'h0);
    wr(ADDR_MODE, {29'h0, MS_NORMAL});
    rd(ADDR_STAT, 32'hF, 32'h2);
    pulse(1'b1);
    wait_fs;
    chk({31'h0, reg_en}, 32'h1);
    rd(ADDR_IRQ_STAT, 32'h2, 32'h2);
    chk({31'h0, int_line}, 32'h0);
    wr(ADDR_IRQ_MASK, 32'h2);
    repeat (2) @(posedge pclk);
    chk({30'h0, irq, int_line}, 32'h1);
    wr(ADDR_IRQ_STAT, 32'h2);
    rd(ADDR_IRQ_STAT, 32'h2, 32'h0);
    wr(ADDR_IRQ_MASK, 32'h0);
    $display("test config 1 done");
    rst(1'b0, 1'b1);
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_MODE, {29'h0, MS_NORMAL});
    wr(ADDR_MODE, {29'h0, MS_STOP});
    pulse(1'b0);
    rd(ADDR_IRQ_STAT, 32'h1, 32'h1);
    wr(ADDR_MODE, {29'h0, MS_NORMAL});
    rd(ADDR_STAT, 32'h1C00, 32'h1000);
    pulse(1'b1);
    repeat (5) @(posedge pclk);
    chk({31'h0, fs_line}, 32'h1);
    pulse(1'b1);
    wait_fs;
    chk({31'h0, reg_en}, 32'h0);
    rd(ADDR_STAT, 32'hF, 32'h7);
    $display("test config 4 done");
    rst(1'b1, 1'b1);
    chk({31'h0, fs_line}, 32'h1);
    wait_fs;
    rd(ADDR_IRQ_STAT, 32'h4, 32'h4);
    $display("test init timeout done");
    rst(1'b1, 1'b0);
    wr(ADDR_MODE, {29'h0, MS_NORMAL});
    rd(ADDR_STAT, 32'h1C00, 32'h0);
    pulse(1'b1);
    repeat (5) @(posedge pclk);
    chk({30'h0, reg_en, fs_line}, 32'h3);
    wr(ADDR_CTRL, 32'h22);
    rd(ADDR_STAT, 32'h1C00, 32'h0800);
    pulse(1'b1);
    wait_fs;
    chk({31'h0, reg_en}, 32'h0);
    $display("test development mode done");
    end_of_test;
  end
endmodule : tb_smc_ctrl
